// File: rtl/fswsg_defs.vh
`ifndef FSWSG_DEFS_VH
`define FSWSG_DEFS_VH

// register word offsets (consecutive word addresses)
`define FSWSG_OFF_CTRL 4'h0
`define FSWSG_OFF_PRESCALE 4'h1
`define FSWSG_OFF_BUS_TIMEOUT 4'h2
`define FSWSG_OFF_LOCAL_TIMEOUT 4'h3
`define FSWSG_OFF_STATUS 4'h4
`define FSWSG_OFF_STATE_REQ 4'h5

// control field positions
`define FSWSG_CTRL_BUS_EN 0
`define FSWSG_CTRL_LOCAL_EN 1

// status field positions
`define FSWSG_ST_BUS_EXP 0
`define FSWSG_ST_LOCAL_EXP 1
`define FSWSG_ST_ERR 2
`define FSWSG_ST_STATE_LSB 4

// reset values
`define FSWSG_RST_PRESCALE 16'h09c2
`define FSWSG_RST_BUS_TIMEOUT 16'h03e8
`define FSWSG_RST_LOCAL_TIMEOUT 16'h03e8
`define FSWSG_RST_CTRL 2'h3

// base clocks beyond the prescaler value per watchdog tick
`define FSWSG_TICK_EXTRA 17'h00002

// slave states
`define FSWSG_ST_INIT 3'h1
`define FSWSG_ST_PREOP 3'h2
`define FSWSG_ST_BOOT 3'h3
`define FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT 3'h4
`define FSWSG_ST_OP 3'h5

`endif

// File: rtl/fswsg_watchdog.v
// Behaviour
// - two independent watchdogs, bus side and local interface, both default 100 ms
// - bus watchdog restarts only on a successful process-data exchange
// - bus watchdog expiry forces all outputs false
// - bus watchdog expiry leaves the slave state unchanged
// - local watchdog triggers when the application side stays idle too long
// - one shared prescaler, separate count each; timeout is count times tick
// - one tick every prescaler plus 2 base clock periods
// - prescaler resets to 2498, a 100 us tick
// - bus timeout count resets to 1000 ticks
// - counts 0 to 65535, prescaler 1 to 65535 accepted
// - enabled bus watchdog with count 0 is disabled entirely
// - power-on enters init; no mailbox and no process data there
// - init to pre_operational_state checks mailbox setup; pre_operational_state allows mailbox only
// - pre_operational_state to safe_operational_state checks channels and clocks, snapshots inputs first
// - safe_operational_state allows mailbox and process data, updates inputs, holds outputs safe
// - with watchdog off, outputs may be driven in safe_operational_state
// - op copies master outputs to physical outputs; all traffic allowed
// - boot state only from init; file-access mailbox only, no process data
module fswsg_watchdog (
  input wire mclk_in,
  input wire resetn_in,
  input wire [3:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire bus_pd_exchange_in,
  input wire local_access_in,
  input wire mailbox_ok_in,
  input wire pd_channels_ok_in,
  input wire clocks_ok_in,
  input wire [7:0] master_outputs_in,
  input wire [7:0] field_inputs_in,
  output reg [7:0] phys_outputs_out,
  output reg [7:0] input_snapshot_out,
  output reg [2:0] slave_state_out,
  output reg mailbox_allowed_out,
  output reg file_access_only_out,
  output reg pd_allowed_out,
  output reg bus_wd_expired_out,
  output reg local_wd_expired_out
);
`include "fswsg_defs.vh"

  // bus transfer state
  reg ack_q;
  reg [1:0] ctrl_q;
  reg [15:0] prescale_q;
  reg [15:0] bus_timeout_q;
  reg [15:0] local_timeout_q;
  reg [16:0] pre_cnt_q;
  reg tick_q;
  reg [15:0] bus_cnt_q;
  reg [15:0] local_cnt_q;
  reg bus_exp_q;
  reg local_exp_q;
  reg err_q;
  reg [2:0] state_q;
  reg [2:0] state_req_q;
  reg req_pending_q;
  wire bus_wr;
  wire bus_rd;
  wire bus_wd_on;
  wire local_wd_on;
  wire outputs_live;
  wire safe_operational_state_alt_ok;

  // a request is answered one cycle after it appears; reads are registered on the
  // first cycle so data stand at the answer, writes land on the answer edge itself
  assign bus_wr = avs_write_in & ack_q;
  assign bus_rd = avs_read_in & ~ack_q;

  // a zero count switches a watchdog off altogether
  assign bus_wd_on = ctrl_q[`FSWSG_CTRL_BUS_EN] & (bus_timeout_q != 16'h0000);
  assign local_wd_on = ctrl_q[`FSWSG_CTRL_LOCAL_EN] & (local_timeout_q != 16'h0000);

  // outputs follow master data in op, and in safe_operational_state only with the bus watchdog off
  assign outputs_live = ((state_q == `FSWSG_ST_OP) |
    ((state_q == `FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT) & ~bus_wd_on)) & ~bus_exp_q;

  // the pre_operational_state to safe_operational_state check, shared by the state machine and the input image
  assign safe_operational_state_alt_ok = req_pending_q & (state_q == `FSWSG_ST_PREOP) &
    (state_req_q == `FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT) & pd_channels_ok_in & clocks_ok_in;

  // true once a count has reached its limit; both watchdogs share this test
  function fswsg_reached;
    input [15:0] cnt;
    input [15:0] limit;
    begin
      fswsg_reached = (cnt >= limit);
    end
  endfunction

  // states in which process data flows; used by the gate and the input image
  function fswsg_pd_state;
    input [2:0] st;
    begin
      fswsg_pd_state = (st == `FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT) | (st == `FSWSG_ST_OP);
    end
  endfunction

  // next count after a tick; saturates at the limit so expiry is a level
  function [15:0] fswsg_step;
    input [15:0] cnt;
    input [15:0] limit;
    begin
      if (fswsg_reached(cnt, limit))
        fswsg_step = cnt;
      else
        fswsg_step = cnt + 16'h0001;
    end
  endfunction

  // waitrequest handshake: one wait cycle then an answer
  // the fixed single wait state keeps answer timing independent of the address
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      ack_q <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~ack_q);
    end
  end

  // configuration registers written by the master
  // writes to status or unmapped words fall through and change nothing
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      ctrl_q <= `FSWSG_RST_CTRL;
      prescale_q <= `FSWSG_RST_PRESCALE;
      bus_timeout_q <= `FSWSG_RST_BUS_TIMEOUT;
      local_timeout_q <= `FSWSG_RST_LOCAL_TIMEOUT;
    end
    else if (bus_wr)
    begin
      case (avs_address_in)
        `FSWSG_OFF_CTRL: ctrl_q <= avs_writedata_in[1:0];
        `FSWSG_OFF_PRESCALE:
          // a zero prescaler is outside the accepted range and is dropped
          if (avs_writedata_in[15:0] != 16'h0000)
            prescale_q <= avs_writedata_in[15:0];
        `FSWSG_OFF_BUS_TIMEOUT: bus_timeout_q <= avs_writedata_in[15:0];
        `FSWSG_OFF_LOCAL_TIMEOUT: local_timeout_q <= avs_writedata_in[15:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // register read mux; unmapped reads return zero
  // status is built from live flags, so a read never clears them
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
      avs_readdata_out <= 32'h00000000;
    else if (bus_rd)
    begin
      case (avs_address_in)
        `FSWSG_OFF_CTRL: avs_readdata_out <= {30'h0, ctrl_q};
        `FSWSG_OFF_PRESCALE: avs_readdata_out <= {16'h0000, prescale_q};
        `FSWSG_OFF_BUS_TIMEOUT: avs_readdata_out <= {16'h0000, bus_timeout_q};
        `FSWSG_OFF_LOCAL_TIMEOUT: avs_readdata_out <= {16'h0000, local_timeout_q};
        `FSWSG_OFF_STATUS: avs_readdata_out <= {25'h0, state_q, 1'b0, err_q,
          local_exp_q, bus_exp_q};
        `FSWSG_OFF_STATE_REQ: avs_readdata_out <= {29'h0, state_req_q};
        default: avs_readdata_out <= 32'h00000000;
      endcase
    end
  end

  // shared prescaler: a tick every prescaler + 2 base clocks
  // the count runs from 0 to prescaler + 1, which gives that period exactly
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      pre_cnt_q <= 17'h00000;
      tick_q <= 1'b0;
    end
    else if (pre_cnt_q >= ({1'b0, prescale_q} + `FSWSG_TICK_EXTRA - 17'h00001))
    begin
      pre_cnt_q <= 17'h00000;
      tick_q <= 1'b1;
    end
    else
    begin
      pre_cnt_q <= pre_cnt_q + 17'h00001;
      tick_q <= 1'b0;
    end
  end

  // bus-side watchdog; only an exchange restarts it
  // the count saturates, so expiry stays a level until traffic returns
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      bus_cnt_q <= 16'h0000;
      bus_exp_q <= 1'b0;
    end
    else if (bus_pd_exchange_in | ~bus_wd_on)
    begin
      bus_cnt_q <= 16'h0000;
      bus_exp_q <= 1'b0;
    end
    else
    begin
      if (tick_q)
        bus_cnt_q <= fswsg_step(bus_cnt_q, bus_timeout_q);
      if (fswsg_reached(bus_cnt_q, bus_timeout_q))
        bus_exp_q <= 1'b1;
    end
  end

  // local-interface watchdog
  // a local expiry only raises its flag; it never touches the outputs
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      local_cnt_q <= 16'h0000;
      local_exp_q <= 1'b0;
    end
    else if (local_access_in | ~local_wd_on)
    begin
      local_cnt_q <= 16'h0000;
      local_exp_q <= 1'b0;
    end
    else
    begin
      if (tick_q)
        local_cnt_q <= fswsg_step(local_cnt_q, local_timeout_q);
      if (fswsg_reached(local_cnt_q, local_timeout_q))
        local_exp_q <= 1'b1;
    end
  end

  // slave state machine; watchdog expiry never enters here
  // a request waits one cycle so the setup checks are sampled after the write;
  // a refused or failing request keeps the state and raises the error bit
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      state_q <= `FSWSG_ST_INIT;
      state_req_q <= `FSWSG_ST_INIT;
      req_pending_q <= 1'b0;
      err_q <= 1'b0;
    end
    else if (bus_wr & (avs_address_in == `FSWSG_OFF_STATE_REQ))
    begin
      state_req_q <= avs_writedata_in[2:0];
      req_pending_q <= 1'b1;
    end
    else if (req_pending_q)
    begin
      req_pending_q <= 1'b0;
      err_q <= 1'b1;
      case (state_q)
        `FSWSG_ST_INIT:
          if (state_req_q == `FSWSG_ST_PREOP && mailbox_ok_in)
          begin
            state_q <= `FSWSG_ST_PREOP;
            err_q <= 1'b0;
          end
          else if (state_req_q == `FSWSG_ST_BOOT && mailbox_ok_in)
          begin
            state_q <= `FSWSG_ST_BOOT;
            err_q <= 1'b0;
          end
          else if (state_req_q == `FSWSG_ST_INIT)
            err_q <= 1'b0;
        `FSWSG_ST_PREOP:
          if (safe_operational_state_alt_ok)
          begin
            state_q <= `FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT;
            err_q <= 1'b0;
          end
          else if (state_req_q == `FSWSG_ST_INIT || state_req_q == `FSWSG_ST_PREOP)
          begin
            state_q <= state_req_q;
            err_q <= 1'b0;
          end
        `FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT, `FSWSG_ST_OP:
          // the master is trusted to have supplied valid outputs before op
          if (state_req_q == `FSWSG_ST_OP || state_req_q == `FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT ||
              state_req_q == `FSWSG_ST_PREOP || state_req_q == `FSWSG_ST_INIT)
          begin
            state_q <= state_req_q;
            err_q <= 1'b0;
          end
        `FSWSG_ST_BOOT:
          if (state_req_q == `FSWSG_ST_INIT || state_req_q == `FSWSG_ST_BOOT)
          begin
            state_q <= state_req_q;
            err_q <= 1'b0;
          end
        default: state_q <= `FSWSG_ST_INIT;
      endcase
    end
  end

  // input image: captured by the safe_operational_state entry check, then refreshed every cycle
  // in safe_operational_state and op; a bus write in flight does not stall the refresh
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
      input_snapshot_out <= 8'h00;
    else if (safe_operational_state_alt_ok)
      input_snapshot_out <= field_inputs_in;
    else if (fswsg_pd_state(state_q))
      input_snapshot_out <= field_inputs_in;
  end

  // registered output image and visible state
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      phys_outputs_out <= 8'h00;
      slave_state_out <= `FSWSG_ST_INIT;
    end
    else
    begin
      phys_outputs_out <= outputs_live ? master_outputs_in : 8'h00;
      slave_state_out <= state_q;
    end
  end

  // traffic permissions per state
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      mailbox_allowed_out <= 1'b0;
      file_access_only_out <= 1'b0;
      pd_allowed_out <= 1'b0;
    end
    else
    begin
      mailbox_allowed_out <= (state_q != `FSWSG_ST_INIT);
      file_access_only_out <= (state_q == `FSWSG_ST_BOOT);
      pd_allowed_out <= fswsg_pd_state(state_q);
    end
  end

  // expiry flags, one cycle behind the watchdogs like the gated outputs
  always @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      bus_wd_expired_out <= 1'b0;
      local_wd_expired_out <= 1'b0;
    end
    else
    begin
      bus_wd_expired_out <= bus_exp_q;
      local_wd_expired_out <= local_exp_q;
    end
  end

endmodule

// File: verif/fswsg_checker.sv
`include "fswsg_defs.vh"
module fswsg_checker (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic bus_pd_exchange_in,
  input wire logic local_access_in,
  input wire logic [7:0] field_inputs_in,
  input wire logic [7:0] phys_outputs_out,
  input wire logic [7:0] input_snapshot_out,
  input wire logic [2:0] slave_state_out,
  input wire logic pd_allowed_out,
  input wire logic bus_wd_expired_out,
  input wire logic local_wd_expired_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // states below safe_operational_state never carry process data
  wire low_st = slave_state_out < `FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT;
  wire req = avs_read_in || avs_write_in;
  chk_bus_answer: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  chk_exp_zero: assert property (bus_wd_expired_out |-> phys_outputs_out == 8'h00)
    else $error("outputs live after bus expiry");
  chk_exp_state: assert property ($rose(bus_wd_expired_out) |-> $stable(slave_state_out))
    else $error("state moved on expiry");
  chk_bus_clear: assert property (bus_pd_exchange_in && bus_wd_expired_out
    |-> ##2 !bus_wd_expired_out)
    else $error("bus flag kept after exchange");
  chk_local_clear: assert property (local_access_in && local_wd_expired_out
    |-> ##2 !local_wd_expired_out)
    else $error("local flag kept after access");
  chk_quiet_off: assert property (low_st ##1 low_st |-> phys_outputs_out == 8'h00)
    else $error("outputs driven below safe_operational_state");
  chk_pd_gate: assert property (pd_allowed_out && $stable(slave_state_out)
    |-> !low_st)
    else $error("process data allowed below safe_operational_state");
  chk_boot_entry: assert property ($changed(slave_state_out)
    && slave_state_out == `FSWSG_ST_BOOT |-> $past(slave_state_out) == `FSWSG_ST_INIT)
    else $error("boot entered from other than init");
  chk_snap_track: assert property (slave_state_out == `FSWSG_ST_OP
    && $stable(slave_state_out) |=> input_snapshot_out == $past(field_inputs_in))
    else $error("snapshot not tracking inputs");
  cover property ($rose(bus_wd_expired_out));
  cover property ($rose(local_wd_expired_out));
  cover property (slave_state_out == `FSWSG_ST_BOOT);
endmodule
bind fswsg_watchdog fswsg_checker fswsg_checker_inst (.mclk_in(mclk_in),
  .resetn_in(resetn_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .bus_pd_exchange_in(bus_pd_exchange_in),
  .local_access_in(local_access_in), .field_inputs_in(field_inputs_in),
  .phys_outputs_out(phys_outputs_out), .input_snapshot_out(input_snapshot_out),
  .slave_state_out(slave_state_out), .pd_allowed_out(pd_allowed_out),
  .bus_wd_expired_out(bus_wd_expired_out), .local_wd_expired_out(local_wd_expired_out));

// File: verif/fswsg_master_model.sv
module fswsg_master_model (
  input wire logic mclk_in,
  input wire logic run_in,
  output logic pd_exchange_out = 1'b0,
  output logic [7:0] data_out,
  output logic setup_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // valid output image exists before op is asked for
  assign data_out = 8'ha5;
  // mailbox on channels 0 and 1, process data from channel 2, clocks right
  assign setup_ok_out = 1'b1;
  // one exchange every other cycle while the link is up
  always @(posedge mclk_in)
    pd_exchange_out <= run_in && !pd_exchange_out;
endmodule

// File: verif/fswsg_watchdog_bench.sv
`include "fswsg_defs.vh"
module fswsg_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic local_access_in = 1'b1;
  logic [7:0] field_inputs_in = 8'h3c;
  logic run = 1'b0;
  logic [31:0] rd;
  int err_count = 0;
  int n_checks = 0;
  int n;
  wire [31:0] avs_readdata_out;
  wire [7:0] master_outputs_in, phys_outputs_out, input_snapshot_out;
  wire [2:0] slave_state_out;
  wire avs_waitrequest_out, bus_pd_exchange_in, mailbox_ok_in, pd_channels_ok_in, clocks_ok_in;
  wire mailbox_allowed_out, file_access_only_out, pd_allowed_out;
  wire bus_wd_expired_out, local_wd_expired_out;
  // setup checks all come from the one master view
  assign pd_channels_ok_in = mailbox_ok_in;
  assign clocks_ok_in = mailbox_ok_in;
  always #20 mclk_in = ~mclk_in;
  fswsg_watchdog fswsg_watchdog_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .bus_pd_exchange_in(bus_pd_exchange_in),
    .local_access_in(local_access_in), .mailbox_ok_in(mailbox_ok_in),
    .pd_channels_ok_in(pd_channels_ok_in), .clocks_ok_in(clocks_ok_in),
    .master_outputs_in(master_outputs_in), .field_inputs_in(field_inputs_in),
    .phys_outputs_out(phys_outputs_out), .input_snapshot_out(input_snapshot_out),
    .slave_state_out(slave_state_out), .mailbox_allowed_out(mailbox_allowed_out),
    .file_access_only_out(file_access_only_out), .pd_allowed_out(pd_allowed_out),
    .bus_wd_expired_out(bus_wd_expired_out), .local_wd_expired_out(local_wd_expired_out));
  fswsg_master_model fswsg_master_model_inst (.mclk_in(mclk_in), .run_in(run),
    .pd_exchange_out(bus_pd_exchange_in), .data_out(master_outputs_in),
    .setup_ok_out(mailbox_ok_in));
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // hold the request until waitrequest is seen low, then release
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // wait for the answer however long it takes; only the bench time limit ends a hang
    do
      @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, rd);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk_in);
  endtask
  // state request, then time for evaluation and the visible update
  task automatic go(input logic [2:0] s);
    bus(1'b1, `FSWSG_OFF_STATE_REQ, {29'h0, s});
    tick(3);
  endtask
  task automatic look(input logic [5:0] e);
    chk("state_gate", {26'h0, e}, {26'h0, slave_state_out, mailbox_allowed_out,
      file_access_only_out, pd_allowed_out});
  endtask
  initial
  begin
    #200000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    tick(5);
    resetn_in <= 1'b1;
    rdchk("ctrl", `FSWSG_OFF_CTRL, 32'h3);
    rdchk("presc", `FSWSG_OFF_PRESCALE, 32'h9c2);
    rdchk("bus_to", `FSWSG_OFF_BUS_TIMEOUT, 32'h3e8);
    rdchk("loc_to", `FSWSG_OFF_LOCAL_TIMEOUT, 32'h3e8);
    rdchk("status", `FSWSG_OFF_STATUS, 32'h10);
    rdchk("unmapped", 4'hf, 32'h0);
    look({3'h1, 3'b000});
    bus(1'b1, `FSWSG_OFF_PRESCALE, 32'h0);
    rdchk("presc0", `FSWSG_OFF_PRESCALE, 32'h9c2);
    bus(1'b1, `FSWSG_OFF_BUS_TIMEOUT, 32'hffff);
    rdchk("to_max", `FSWSG_OFF_BUS_TIMEOUT, 32'hffff);
    // short counts keep expiry within a few dozen cycles
    bus(1'b1, `FSWSG_OFF_PRESCALE, 32'h1);
    bus(1'b1, `FSWSG_OFF_BUS_TIMEOUT, 32'h2);
    bus(1'b1, `FSWSG_OFF_LOCAL_TIMEOUT, 32'h2);
    run <= 1'b1;
    go(`FSWSG_ST_PREOP);
    look({3'h2, 3'b100});
    go(`FSWSG_ST_SAFE_OPERATIONAL_STATE_ALT);
    look({3'h4, 3'b101});
    chk("snap", 32'h3c, {24'h0, input_snapshot_out});
    chk("so_out", 32'h0, {24'h0, phys_outputs_out});
    bus(1'b1, `FSWSG_OFF_CTRL, 32'h2);
    tick(2);
    chk("so_live", 32'ha5, {24'h0, phys_outputs_out});
    bus(1'b1, `FSWSG_OFF_CTRL, 32'h3);
    go(`FSWSG_ST_OP);
    look({3'h5, 3'b101});
    chk("op_out", 32'ha5, {24'h0, phys_outputs_out});
    field_inputs_in <= 8'hc3;
    tick(2);
    chk("snap_op", 32'hc3, {24'h0, input_snapshot_out});
    go(`FSWSG_ST_BOOT);
    rdchk("boot_refused", `FSWSG_OFF_STATUS, 32'h54);
    // stop exchanges and time the expiry: 2 ticks of 3 clocks plus phase
    run <= 1'b0;
    n = 0;
    while (bus_wd_expired_out !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    chk("exp_time", 32'h1, {31'h0, n >= 5 && n <= 12});
    tick(2);
    chk("exp_out", 32'h500, {21'h0, slave_state_out, phys_outputs_out});
    run <= 1'b1;
    tick(4);
    chk("resume", 32'ha5, {23'h0, bus_wd_expired_out, phys_outputs_out});
    bus(1'b1, `FSWSG_OFF_BUS_TIMEOUT, 32'h0);
    run <= 1'b0;
    tick(40);
    chk("count0", 32'ha5, {23'h0, bus_wd_expired_out, phys_outputs_out});
    local_access_in <= 1'b0;
    tick(30);
    chk("loc_exp", 32'h1, {31'h0, local_wd_expired_out});
    local_access_in <= 1'b1;
    tick(3);
    chk("loc_clr", 32'h0, {31'h0, local_wd_expired_out});
    go(`FSWSG_ST_INIT);
    look({3'h1, 3'b000});
    go(`FSWSG_ST_BOOT);
    chk("boot", 32'he, {27'h0, slave_state_out, file_access_only_out, pd_allowed_out});
    end_of_test;
  end
endmodule
